// ### hdl/timer_compare_regs.svh
// register map, field positions, reset values and counts of the 8-bit timer
`ifndef TIMER_COMPARE_REGS_SVH
`define TIMER_COMPARE_REGS_SVH

// register addresses on the plain register port
`define TC_ADDR_CTRL 3'h0
`define TC_ADDR_COUNT 3'h1
`define TC_ADDR_COMPARE 3'h2
`define TC_ADDR_FLAGS 3'h3
`define TC_ADDR_MASK 3'h4

// control register fields
`define TC_FORCE_BIT 7
`define TC_WGM0_BIT 6
`define TC_COM_HI 5
`define TC_COM_LO 4
`define TC_WGM1_BIT 3
`define TC_CS_HI 2
`define TC_CS_LO 0

// flag and mask register fields
`define TC_CMP_BIT 1
`define TC_OVF_BIT 0

// reset values
`define TC_CTRL_RST 8'h00
`define TC_COUNT_RST 8'h00
`define TC_COMPARE_RST 8'h00

// extreme counter values
`define TC_BOTTOM 8'h00
`define TC_MAX 8'hff

// clock source select codes
`define TC_CS_STOP 3'h0
`define TC_CS_DIV1 3'h1
`define TC_CS_DIV8 3'h2
`define TC_CS_DIV32 3'h3
`define TC_CS_DIV64 3'h4
`define TC_CS_DIV128 3'h5
`define TC_CS_DIV256 3'h6
`define TC_CS_DIV1024 3'h7

// prescaler masks: a tick when the masked prescaler bits are all ones
`define TC_PRE_MASK8 10'h007
`define TC_PRE_MASK32 10'h01f
`define TC_PRE_MASK64 10'h03f
`define TC_PRE_MASK128 10'h07f
`define TC_PRE_MASK256 10'h0ff
`define TC_PRE_MASK1024 10'h3ff

`endif

// ### hdl/timer_compare_pkg.sv
// types shared by the 8-bit timer and its users
package timer_compare_pkg;

    // waveform modes, encoded {wgm1, wgm0}
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_PHASE_PWM = 2'b01,
        MODE_FAST_PWM = 2'b11,
        MODE_CLEAR_ON_MATCH = 2'b10
    } wave_mode_t;

    // compare output mode actions
    typedef enum logic [1:0] {
        COM_NONE = 2'b00,
        COM_TOGGLE = 2'b01,
        COM_CLEAR = 2'b10,
        COM_SET = 2'b11
    } compare_output_mode_t;

    // one request on the register port
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

// ### hdl/eight_bit_timer_compare_unit.sv
// 8-bit timer/counter with one compare unit and a waveform pin stage
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`include "timer_compare_regs.svh"

// Behaviour
// [R1] each timer tick clears, increments or decrements the counter per mode
// [R2] clock source select zero stops the timer, no ticks
// [R3] software reads and writes the counter at any time
// [R4] a software counter write beats a same-cycle clear or count
// [R5] the two waveform mode bits in control choose the count sequence
// [R6] overflow flag set where the mode says; can request an interrupt
// [R7] an 8-bit comparator flags equality of counter and compare value
// [R8] compare-match flag set on the tick after the match, not same cycle
// [R9] compare irq enable one lets the flag raise a compare interrupt
// [R10] flag clears on interrupt service or on writing one to it
// [R11] bottom indication whenever the counter is zero
// [R12] compare value double buffered in PWM modes, direct otherwise
// [R13] compare output mode sets next match action and the pin source
// [R14] any compare output mode bit set puts waveform on the pin
// [R15] software sets the pin direction to output to see the waveform
// [R16] pin override applies in every waveform mode
// [R17] waveform state may be set up before the pin is enabled
// [R18] compare output mode zero leaves waveform state alone on match
// [R19] new compare output mode acts from the first match after write
// [R20] force strobe in non-PWM modes applies the match action at once
// [R21] software avoids compare output modes reserved in the current mode
// [R22] match, max and bottom handle extreme counter values
// [R23] PWM compare buffer copies at top or bottom per mode
// [R24] reset clears counter, compare, flags, modes, waveform; timer stopped
module eight_bit_timer_compare_unit #(
    parameter int PRE_WIDTH = 10
) (
    input wire logic clk,
    input wire logic nrst,
    input timer_compare_pkg::reg_req_t busReq,
    output logic [7:0] rdata,
    input wire logic compareIrqAck,
    input wire logic overflowIrqAck,
    output logic compareIrq,
    output logic overflowIrq,
    input wire logic portData,
    input wire logic waveformPinDirection,
    output logic pinOut,
    output logic pinOeN
);

    logic [7:0] timerControl;
    logic [7:0] timerCount;
    logic [7:0] compareBuffer;
    logic [7:0] compareActive;
    logic compareMatchFlag;
    logic overflowFlag;
    logic compareIrqEnable;
    logic overflowIrqEnable;
    logic waveformOutput;
    logic countDown;
    logic [PRE_WIDTH-1:0] prescaler;
    logic timerTick;
    logic match;
    logic atMax;
    logic atBottom;
    logic pwmMode;
    logic wrCtrl;
    logic wrCount;
    logic wrCompare;
    logic wrFlags;
    logic wrMask;
    logic forceStrobe;
    logic [2:0] clockSourceSelect;
    logic [7:0] next_count;
    logic next_countDown;
    logic overflowEvent;
    logic bufferUpdate;
    logic next_wave;
    timer_compare_pkg::wave_mode_t waveformMode;
    timer_compare_pkg::compare_output_mode_t compareOutputMode;

    // control fields; mode and action are live, so changes act at once
    assign waveformMode = timer_compare_pkg::wave_mode_t'(
        {timerControl[`TC_WGM1_BIT], timerControl[`TC_WGM0_BIT]}); // R5
    assign compareOutputMode = timer_compare_pkg::compare_output_mode_t'(
        timerControl[`TC_COM_HI:`TC_COM_LO]);
    assign clockSourceSelect = timerControl[`TC_CS_HI:`TC_CS_LO];
    assign pwmMode = timerControl[`TC_WGM0_BIT];

    // address decode of the register port
    always_comb begin
        wrCtrl = 1'b0;
        wrCount = 1'b0;
        wrCompare = 1'b0;
        wrFlags = 1'b0;
        wrMask = 1'b0;
        if (busReq.wr && busReq.addr == `TC_ADDR_CTRL) begin
            wrCtrl = 1'b1;
        end else if (busReq.wr && busReq.addr == `TC_ADDR_COUNT) begin
            wrCount = 1'b1;
        end else if (busReq.wr && busReq.addr == `TC_ADDR_COMPARE) begin
            wrCompare = 1'b1;
        end else if (busReq.wr && busReq.addr == `TC_ADDR_FLAGS) begin
            wrFlags = 1'b1;
        end else if (busReq.wr && busReq.addr == `TC_ADDR_MASK) begin
            wrMask = 1'b1;
        end
    end

    // force only means something outside PWM modes
    assign forceStrobe = wrCtrl && busReq.wdata[`TC_FORCE_BIT]
        && !busReq.wdata[`TC_WGM0_BIT]; // R20

    // control register; the force bit is a strobe and is never stored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timerControl <= `TC_CTRL_RST; // R24
        end else if (wrCtrl) begin
            timerControl <= busReq.wdata & ~(8'h01 << `TC_FORCE_BIT);
        end
    end

    // free-running prescaler, held in reset while the timer is stopped
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prescaler <= '0;
        end else if (clockSourceSelect == `TC_CS_STOP) begin
            prescaler <= '0;
        end else begin
            prescaler <= prescaler + 1'b1;
        end
    end

    // tick selection from the prescaler taps
    always_comb begin
        case (clockSourceSelect)
            `TC_CS_STOP: timerTick = 1'b0; // R2
            `TC_CS_DIV1: timerTick = 1'b1;
            `TC_CS_DIV8: timerTick =
                (prescaler & `TC_PRE_MASK8) == `TC_PRE_MASK8;
            `TC_CS_DIV32: timerTick =
                (prescaler & `TC_PRE_MASK32) == `TC_PRE_MASK32;
            `TC_CS_DIV64: timerTick =
                (prescaler & `TC_PRE_MASK64) == `TC_PRE_MASK64;
            `TC_CS_DIV128: timerTick =
                (prescaler & `TC_PRE_MASK128) == `TC_PRE_MASK128;
            `TC_CS_DIV256: timerTick =
                (prescaler & `TC_PRE_MASK256) == `TC_PRE_MASK256;
            default: timerTick =
                (prescaler & `TC_PRE_MASK1024) == `TC_PRE_MASK1024;
        endcase
    end

    // comparator and extreme value indications
    assign match = timerCount == compareActive; // R7
    assign atMax = timerCount == `TC_MAX;
    assign atBottom = timerCount == `TC_BOTTOM; // R11

    // count sequence per mode; the phase-correct mode turns at both ends
    always_comb begin
        next_count = timerCount;
        next_countDown = countDown;
        case (waveformMode)
            timer_compare_pkg::MODE_CLEAR_ON_MATCH: begin
                next_count = match ? `TC_BOTTOM : timerCount + 8'h01; // R1
            end
            timer_compare_pkg::MODE_PHASE_PWM: begin
                if (!countDown && atMax) begin
                    next_count = timerCount - 8'h01; // R22
                    next_countDown = 1'b1;
                end else if (countDown && atBottom) begin
                    next_count = timerCount + 8'h01; // R22
                    next_countDown = 1'b0;
                end else if (countDown) begin
                    next_count = timerCount - 8'h01; // R1
                end else begin
                    next_count = timerCount + 8'h01; // R1
                end
            end
            default: begin
                next_count = timerCount + 8'h01; // R1
            end
        endcase
    end

    // counter; a software write always wins over the tick
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timerCount <= `TC_COUNT_RST;
        end else if (wrCount) begin
            timerCount <= busReq.wdata; // R3 R4
        end else if (timerTick) begin
            timerCount <= next_count; // R1
        end
    end

    // count direction, only used by the phase-correct mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            countDown <= 1'b0;
        end else if (waveformMode !=
                timer_compare_pkg::MODE_PHASE_PWM) begin
            countDown <= 1'b0;
        end else if (timerTick && !wrCount) begin
            countDown <= next_countDown;
        end
    end

    // overflow point: bottom in phase-correct, max elsewhere
    assign overflowEvent = timerTick && !wrCount &&
        ((waveformMode == timer_compare_pkg::MODE_PHASE_PWM)
            ? (countDown && atBottom) : atMax); // R6

    // buffer copy point: top for phase-correct, bottom for fast PWM
    assign bufferUpdate = timerTick && !wrCount && atMax &&
        (waveformMode == timer_compare_pkg::MODE_PHASE_PWM ? !countDown
            : waveformMode == timer_compare_pkg::MODE_FAST_PWM); // R23

    // software-visible compare buffer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            compareBuffer <= `TC_COMPARE_RST;
        end else if (wrCompare) begin
            compareBuffer <= busReq.wdata;
        end
    end

    // active compare value: direct outside PWM, buffered inside
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            compareActive <= `TC_COMPARE_RST;
        end else if (wrCompare && !pwmMode) begin
            compareActive <= busReq.wdata; // R12
        end else if (bufferUpdate) begin
            compareActive <= compareBuffer; // R12 R23
        end
    end

    // compare flag: match seen at a tick, so it rises one tick after
    // the counter reaches the value; a set beats a same-cycle clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            compareMatchFlag <= 1'b0;
        end else if (timerTick && match) begin
            compareMatchFlag <= 1'b1; // R8
        end else if (compareIrqAck ||
                (wrFlags && busReq.wdata[`TC_CMP_BIT])) begin
            compareMatchFlag <= 1'b0; // R10
        end
    end

    // overflow flag with the same clearing scheme
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            overflowFlag <= 1'b0;
        end else if (overflowEvent) begin
            overflowFlag <= 1'b1; // R6
        end else if (overflowIrqAck ||
                (wrFlags && busReq.wdata[`TC_OVF_BIT])) begin
            overflowFlag <= 1'b0;
        end
    end

    // interrupt enables
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            compareIrqEnable <= 1'b0;
            overflowIrqEnable <= 1'b0;
        end else if (wrMask) begin
            compareIrqEnable <= busReq.wdata[`TC_CMP_BIT];
            overflowIrqEnable <= busReq.wdata[`TC_OVF_BIT];
        end
    end

    // interrupt requests, registered so the outputs come from flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            compareIrq <= 1'b0;
            overflowIrq <= 1'b0;
        end else begin
            compareIrq <= compareMatchFlag && compareIrqEnable; // R9
            overflowIrq <= overflowFlag && overflowIrqEnable; // R6
        end
    end

    // waveform action; mode bits are read live, so a new setting acts
    // at the first match after it is written
    always_comb begin
        next_wave = waveformOutput;
        case (waveformMode)
            timer_compare_pkg::MODE_FAST_PWM: begin
                // toggle is reserved here and does nothing
                if (timerTick && match) begin
                    if (compareOutputMode == timer_compare_pkg::COM_CLEAR)
                        next_wave = 1'b0;
                    else if (compareOutputMode == timer_compare_pkg::COM_SET)
                        next_wave = 1'b1;
                end else if (timerTick && atMax) begin
                    // reaching bottom restores the idle level
                    if (compareOutputMode == timer_compare_pkg::COM_CLEAR)
                        next_wave = 1'b1; // R22
                    else if (compareOutputMode == timer_compare_pkg::COM_SET)
                        next_wave = 1'b0; // R22
                end
            end
            timer_compare_pkg::MODE_PHASE_PWM: begin
                // clear type acts low counting up, high counting down
                if (timerTick && match) begin
                    if (compareOutputMode == timer_compare_pkg::COM_CLEAR)
                        next_wave = countDown; // R13
                    else if (compareOutputMode == timer_compare_pkg::COM_SET)
                        next_wave = !countDown; // R13
                end
            end
            default: begin
                if ((timerTick && match) || forceStrobe) begin // R20
                    case (compareOutputMode)
                        timer_compare_pkg::COM_TOGGLE:
                            next_wave = !waveformOutput;
                        timer_compare_pkg::COM_CLEAR: next_wave = 1'b0;
                        timer_compare_pkg::COM_SET: next_wave = 1'b1;
                        default: next_wave = waveformOutput; // R18
                    endcase
                end
            end
        endcase
    end

    // internal waveform state, settable by force while the pin is off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            waveformOutput <= 1'b0; // R24
        end else if (wrCtrl && forceStrobe) begin
            // force uses the mode bits written in the same access
            case (busReq.wdata[`TC_COM_HI:`TC_COM_LO])
                2'h1: waveformOutput <= !waveformOutput; // R17
                2'h2: waveformOutput <= 1'b0; // R17
                2'h3: waveformOutput <= 1'b1; // R17
                default: waveformOutput <= waveformOutput;
            endcase
        end else begin
            waveformOutput <= next_wave; // R13 R19
        end
    end

    // pin stage; direction stays with the port in every mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinOut <= 1'b0;
            pinOeN <= 1'b1;
        end else begin
            pinOut <= (compareOutputMode != timer_compare_pkg::COM_NONE)
                ? waveformOutput : portData; // R14 R16
            pinOeN <= !waveformPinDirection; // R15
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (!busReq.rd) begin
            rdata <= 8'h00;
        end else if (busReq.addr == `TC_ADDR_CTRL) begin
            rdata <= timerControl;
        end else if (busReq.addr == `TC_ADDR_COUNT) begin
            rdata <= timerCount; // R3
        end else if (busReq.addr == `TC_ADDR_COMPARE) begin
            rdata <= compareBuffer;
        end else if (busReq.addr == `TC_ADDR_FLAGS) begin
            rdata <= {6'h00, compareMatchFlag, overflowFlag};
        end else if (busReq.addr == `TC_ADDR_MASK) begin
            rdata <= {6'h00, compareIrqEnable, overflowIrqEnable};
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule // eight_bit_timer_compare_unit

// ### tb/port_pin_model.sv
// port pin logic beside the timer: port data, direction and pad level
module port_pin_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic dataReq,
    input wire logic dirReq,
    input wire logic pinOut,
    input wire logic pinOeN,
    output logic portData,
    output logic waveformPinDirection,
    output logic pinLevel
);
    timeunit 1ns;
    timeprecision 100ps;
    logic lastLevel = 1'b0;
    // port bits as software leaves them; direction is never overridden
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            portData <= 1'b0;
            waveformPinDirection <= 1'b0;
        end else begin
            portData <= dataReq;
            waveformPinDirection <= dirReq;
        end
    end
    // no pull on the pad: a released pin flips so stale values never pass
    always_ff @(posedge clk) lastLevel <= pinLevel;
    assign pinLevel = pinOeN ? ~lastLevel : pinOut;
endmodule // port_pin_model

// ### tb/timer_compare_sva.sv
// concurrent checks on the ports of the 8-bit timer
`include "timer_compare_regs.svh"
module timer_compare_sva (
    input wire logic clk,
    input wire logic nrst,
    input timer_compare_pkg::reg_req_t busReq,
    input wire logic [7:0] rdata,
    input wire logic compareIrqAck,
    input wire logic overflowIrqAck,
    input wire logic compareIrq,
    input wire logic overflowIrq,
    input wire logic portData,
    input wire logic waveformPinDirection,
    input wire logic pinOut,
    input wire logic pinOeN
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] ctrlQ;
    logic [1:0] maskQ;
    logic stopped;
    // shadow of control and enables, rebuilt from bus writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrlQ <= 8'h00;
            maskQ <= 2'h0;
        end else if (busReq.wr) begin
            if (busReq.addr == `TC_ADDR_CTRL) ctrlQ <= busReq.wdata;
            if (busReq.addr == `TC_ADDR_MASK) maskQ <= busReq.wdata[1:0];
        end
    end
    assign stopped = (ctrlQ[2:0] == `TC_CS_STOP);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_read_window;
        !$past(busReq.rd) |-> rdata == 8'h00;
    endproperty
    a_read_window: assert property (p_read_window)
        else $error("read data outside the read slot");
    property p_count_rw;
        (stopped && busReq.wr && busReq.addr == `TC_ADDR_COUNT) ##1
        (busReq.rd && busReq.addr == `TC_ADDR_COUNT)
        |=> rdata == $past(busReq.wdata, 2);
    endproperty
    a_count_rw: assert property (p_count_rw)
        else $error("counter readback differs from write");
    property p_pin_enable;
        pinOeN == !$past(waveformPinDirection);
    endproperty
    a_pin_enable: assert property (p_pin_enable)
        else $error("pin enable does not follow direction");
    property p_port_pass;
        $past(ctrlQ[5:4]) == 2'b00 |-> pinOut == $past(portData);
    endproperty
    a_port_pass: assert property (p_port_pass)
        else $error("pin not from port data with mode zero");
    property p_force;
        busReq.wr && busReq.addr == `TC_ADDR_CTRL && busReq.wdata[7] &&
        !busReq.wdata[6] && busReq.wdata[5]
        |-> ##2 pinOut == $past(busReq.wdata[4], 2);
    endproperty
    a_force: assert property (p_force)
        else $error("forced action missing on pin");
    property p_cmp_en;
        compareIrq |-> $past(maskQ[1]);
    endproperty
    a_cmp_en: assert property (p_cmp_en)
        else $error("compare irq without enable");
    property p_ovf_en;
        overflowIrq |-> $past(maskQ[0]);
    endproperty
    a_ovf_en: assert property (p_ovf_en)
        else $error("overflow irq without enable");
    property p_cmp_ack;
        (compareIrqAck && stopped) ##1 stopped |=> !compareIrq;
    endproperty
    a_cmp_ack: assert property (p_cmp_ack)
        else $error("compare irq survives service");
    property p_tick_needed;
        $rose(compareIrq) && $past(maskQ[1], 2)
        |-> $past(ctrlQ[2:0], 2) != `TC_CS_STOP;
    endproperty
    a_tick_needed: assert property (p_tick_needed)
        else $error("compare flag set while stopped");
    c_cmp: cover property ($rose(compareIrq));
    c_ovf: cover property ($rose(overflowIrq));
    c_drive: cover property (!pinOeN && ctrlQ[5:4] != 2'b00);
endmodule // timer_compare_sva

// ### tb/tb.sv
// self-checking bench for the 8-bit timer with compare unit
`include "timer_compare_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] comSeq = 8'h97;
    localparam logic [3:0] pinSeq = 4'b0101;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    timer_compare_pkg::reg_req_t busReq = '0;
    logic compareIrqAck = 1'b0;
    logic overflowIrqAck = 1'b0;
    logic dataReq = 1'b0;
    logic dirReq = 1'b0;
    logic rdTaken = 1'b0;
    logic [7:0] rdata;
    logic compareIrq, overflowIrq, portData, waveformPinDirection;
    logic pinOut, pinOeN, pinLevel;
    logic [7:0] expQ[$];
    logic [7:0] v;
    int bad_count = 0;
    int comparisons = 0;
    always #2.5 clk = ~clk;
    eight_bit_timer_compare_unit eight_bit_timer_compare_unit_i (
        .clk(clk), .nrst(nrst), .busReq(busReq), .rdata(rdata),
        .compareIrqAck(compareIrqAck), .overflowIrqAck(overflowIrqAck),
        .compareIrq(compareIrq), .overflowIrq(overflowIrq),
        .portData(portData), .waveformPinDirection(waveformPinDirection),
        .pinOut(pinOut), .pinOeN(pinOeN));
    port_pin_model port_pin_model_i (
        .clk(clk), .nrst(nrst), .dataReq(dataReq), .dirReq(dirReq),
        .pinOut(pinOut), .pinOeN(pinOeN), .portData(portData),
        .waveformPinDirection(waveformPinDirection), .pinLevel(pinLevel));
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        check8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        expQ.push_back(e);
    endtask
    // with cs one the timer ticks idle+1 times between two control writes
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            busReq <= '0;
            compareIrqAck <= 1'b0;
            overflowIrqAck <= 1'b0;
        end
    endtask
    task automatic chk_pin(input logic e);
        idle(4);
        @(negedge clk);
        check1(pinLevel, e);
        // hand back on a rising edge so later port stimulus lands there
        @(posedge clk);
    endtask
    task automatic complete_run;
        if (expQ.size() != 0) bad_count++;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) rdTaken <= busReq.rd;
    // read data stands only in the cycle after the strobe
    always @(negedge clk) begin
        if (rdTaken === 1'b1 && expQ.size() > 0) check8(rdata, expQ.pop_front());
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run;
    end
    initial begin
        void'($urandom(76));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a < 6; a++) rd(3'(a), 8'h00);
        v = 8'($urandom);
        wr(`TC_ADDR_COUNT, v);
        rd(`TC_ADDR_COUNT, v);
        wr(`TC_ADDR_COMPARE, 8'h02);
        rd(`TC_ADDR_COMPARE, 8'h02);
        idle(4);
        rd(`TC_ADDR_COUNT, v);
        // wrap from fc through the compare value in normal mode
        wr(`TC_ADDR_MASK, 8'h03);
        wr(`TC_ADDR_COUNT, 8'hfc);
        wr(`TC_ADDR_CTRL, 8'h01);
        idle(8);
        wr(`TC_ADDR_CTRL, 8'h00);
        rd(`TC_ADDR_COUNT, 8'h05);
        rd(`TC_ADDR_FLAGS, 8'h03);
        idle(3);
        @(negedge clk);
        check1(compareIrq, 1'b1);
        check1(overflowIrq, 1'b1);
        wr(`TC_ADDR_FLAGS, 8'h02);
        rd(`TC_ADDR_FLAGS, 8'h01);
        @(posedge clk);
        busReq <= '0;
        overflowIrqAck <= 1'b1;
        idle(1);
        rd(`TC_ADDR_FLAGS, 8'h00);
        // counter write lands on a tick edge while running
        wr(`TC_ADDR_CTRL, 8'h01);
        idle(3);
        v = 8'($urandom_range(224));
        wr(`TC_ADDR_COUNT, v);
        wr(`TC_ADDR_CTRL, 8'h00);
        rd(`TC_ADDR_COUNT, v + 8'h01);
        // clear on match with compare four: twelve ticks end at two
        wr(`TC_ADDR_COUNT, 8'h00);
        wr(`TC_ADDR_COMPARE, 8'h04);
        wr(`TC_ADDR_FLAGS, 8'h03);
        wr(`TC_ADDR_CTRL, 8'h09);
        idle(11);
        wr(`TC_ADDR_CTRL, 8'h08);
        rd(`TC_ADDR_COUNT, 8'h02);
        rd(`TC_ADDR_FLAGS, 8'h02);
        // fast pwm keeps matching the old compare until the update point
        wr(`TC_ADDR_FLAGS, 8'h03);
        wr(`TC_ADDR_CTRL, 8'h48);
        wr(`TC_ADDR_COMPARE, 8'h80);
        wr(`TC_ADDR_COUNT, 8'h00);
        wr(`TC_ADDR_CTRL, 8'h49);
        idle(7);
        wr(`TC_ADDR_CTRL, 8'h48);
        rd(`TC_ADDR_FLAGS, 8'h02);
        @(posedge clk);
        busReq <= '0;
        compareIrqAck <= 1'b1;
        idle(1);
        rd(`TC_ADDR_FLAGS, 8'h00);
        // phase-correct turns at max with no overflow there
        wr(`TC_ADDR_CTRL, 8'h40);
        wr(`TC_ADDR_COUNT, 8'hfe);
        wr(`TC_ADDR_CTRL, 8'h41);
        idle(3);
        wr(`TC_ADDR_CTRL, 8'h40);
        rd(`TC_ADDR_COUNT, 8'hfc);
        rd(`TC_ADDR_FLAGS, 8'h00);
        // divide by eight: first tick eight clocks after start
        wr(`TC_ADDR_COUNT, 8'h00);
        wr(`TC_ADDR_CTRL, 8'h02);
        idle(15);
        wr(`TC_ADDR_CTRL, 8'h00);
        rd(`TC_ADDR_COUNT, 8'h02);
        // forced actions in normal mode, only codes legal there; a force in fast pwm is ignored
        dirReq <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(`TC_ADDR_CTRL, {2'b10, comSeq[2*i+:2], 4'h0});
            chk_pin(pinSeq[i]);
        end
        dataReq <= 1'($urandom);
        wr(`TC_ADDR_CTRL, 8'h80);
        chk_pin(dataReq);
        wr(`TC_ADDR_CTRL, 8'h30);
        chk_pin(1'b0);
        wr(`TC_ADDR_CTRL, 8'hf8);
        chk_pin(1'b0);
        dirReq <= 1'b0;
        idle(3);
        @(negedge clk);
        check1(pinOeN, 1'b1);
        idle(2);
        complete_run;
    end
endmodule // tb
bind eight_bit_timer_compare_unit timer_compare_sva timer_compare_sva_i (
    .clk(clk), .nrst(nrst), .busReq(busReq), .rdata(rdata),
    .compareIrqAck(compareIrqAck), .overflowIrqAck(overflowIrqAck),
    .compareIrq(compareIrq), .overflowIrq(overflowIrq),
    .portData(portData), .waveformPinDirection(waveformPinDirection),
    .pinOut(pinOut), .pinOeN(pinOeN));
